// ### hdl/ppp_port.v
// Parallel programming port: command, address, page buffer, memories
// Functional notes
// R1 - Load strobe with action 00 stores address byte, low/high by pick A.
// R2 - Load strobe with action 01 stores data byte, low/high by pick A.
// R3 - Action 10 loads command byte; action 11 does nothing.
// R4 - Decode write commands: erase, fuses, lock, flash, EEPROM.
// R5 - Decode read commands: signature, fuse/lock, flash, EEPROM.
// R6 - Write strobe or output enable runs the last loaded command.
// R7 - Pick A: 0 low byte, 1 high byte.
// R8 - Pick B: 0 low byte, 1 second high byte.
// R9 - Ready flag low while busy, high when ready.
// R10 - Entry pattern latched at high-voltage rise; programmer holds 0000 10 us.
// R11 - Programmer waits 300 us after high voltage before commands.
// R12 - Command and address stay loaded across operations.
// R13 - Programmer reloads address high byte only on new window.
// R14 - Programmer may skip writing 0xFF after erase.
// R15 - Erase clears flash, EEPROM, lock bits last; fuses kept.
// R16 - Keep-EEPROM fuse programmed: erase spares EEPROM.
// R17 - Programmer waits for ready before next command; device drops ready.
// R18 - Page-latch pulse copies data bytes into page buffer at word index.
// R19 - Flash data collects in a 32-word page buffer.
// R20 - Flash address: bits 4..0 word, bits 11..5 page.
// R21 - EEPROM 512 bytes: bits 1..0 byte, bits 8..2 page.
// R22 - Upper address-low bits select page during page write.
// R23 - Programmer loads address, data, latches per word.
// R24 - At reset, calibration byte copied into oscillator trim register.
// R25 - Three read-only signature bytes at addresses 0 to 2.
// R26 - Write strobe after address load programs whole page, ready low.
// R27 - No-operation command resets internal write signals.
// R28 - Programmer synchronises the ready flag before sampling.
`timescale 1ns/100ps
`default_nettype none
`include "ppp_consts.vh"
module ppp_port #(
  parameter [7:0] SIG0 = 8'h5A, // Arbitrary identity value
  parameter [7:0] SIG1 = 8'h42, // Arbitrary identity value
  parameter [7:0] SIG2 = 8'h07, // Arbitrary identity value
  parameter [7:0] CAL_BYTE = 8'h80
) (
  input wire CLK,
  input wire RESET,
  input wire HV_RESET,
  input wire [3:0] PROG_ENABLE,
  input wire LOAD_STROBE,
  input wire ACTION_CODE_BIT0,
  input wire ACTION_CODE_BIT1,
  input wire BYTE_PICK_A,
  input wire BYTE_PICK_B,
  input wire PAGE_LATCH_STROBE,
  input wire WR_N,
  input wire OE_N,
  input wire [7:0] DATA_IN,
  output reg [7:0] DATA_OUT,
  output reg DATA_OE,
  output reg OP_DONE_FLAG,
  output reg PROG_MODE,
  output reg [7:0] OSC_TRIM_REGISTER,
  output reg [7:0] RD_DATA,
  output reg RD_VALID,
  input wire RD_READY
);
  localparam integer PROG_CYC = `PPP_PROG_US * `PPP_CLK_MHZ;
  localparam integer ERASE_CYC = `PPP_ERASE_US * `PPP_CLK_MHZ;
  localparam integer LATCH_CYC = `PPP_LATCH_US * `PPP_CLK_MHZ;
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_PROG = 4'h2;
  localparam [3:0] ST_ERASE = 4'h4;
  localparam [3:0] ST_LOCK = 4'h8;

  // Two-flop synchronisers for all pin inputs
  wire [18:0] pin_raw = {HV_RESET, LOAD_STROBE, ACTION_CODE_BIT1, ACTION_CODE_BIT0,
    BYTE_PICK_A, BYTE_PICK_B, PAGE_LATCH_STROBE, WR_N, OE_N, PROG_ENABLE, DATA_IN[5:0]};
  reg [18:0] s1_q;
  reg [18:0] s2_q;
  reg [1:0] dhi1_q;
  reg [1:0] dhi2_q;
  reg [4:0] prev_q;
  always @(posedge CLK) begin
    s1_q <= pin_raw;
    s2_q <= s1_q;
    dhi1_q <= DATA_IN[7:6];
    dhi2_q <= dhi1_q;
    prev_q <= {s2_q[18], s2_q[17], s2_q[12], s2_q[11], s2_q[10]};
  end
  wire hv = s2_q[18];
  wire ld = s2_q[17];
  wire [1:0] act = s2_q[16:15];
  wire pick_a = s2_q[14];
  wire pick_b = s2_q[13];
  wire pgl = s2_q[12];
  wire wr_n = s2_q[11];
  wire oe_n = s2_q[10];
  wire [3:0] pen = s2_q[9:6];
  wire [7:0] din = {dhi2_q, s2_q[5:0]};
  wire hv_rise = hv && !prev_q[4];
  wire ld_rise = ld && !prev_q[3];
  wire pgl_rise = pgl && !prev_q[2];
  wire wr_fall = !wr_n && prev_q[1];
  wire oe_low = !oe_n;

  // Memories
  reg [15:0] flash_mem [0:(1 << `PPP_FLASH_AW) - 1];
  reg [7:0] ee_mem [0:(1 << `PPP_EE_AW) - 1];
  reg [15:0] page_buf [0:`PPP_PAGE_WORDS - 1];
  reg [7:0] ee_buf [0:`PPP_EE_PAGE_BYTES - 1];

  reg [7:0] cmd_q;
  reg [15:0] addr_q;
  reg [15:0] dat_q;
  reg [7:0] fuse_lo_q;
  reg [7:0] fuse_hi_q;
  reg [7:0] fuse_ex_q;
  reg [7:0] lock_q;
  reg [3:0] st_q;
  reg [15:0] cnt_q;
  reg [12:0] walk_q;
  reg ee_op_q;
  reg [15:0] latch_q;
  reg latch_arm_q;
  reg [7:0] rd_byte;
  reg rd_push_q;
  wire skid_ready;
  wire idle = (st_q == ST_IDLE);
  wire [6:0] fpage = addr_q[`PPP_FLASH_AW - 1:`PPP_WORD_MSB + 1];
  wire [`PPP_WORD_MSB:0] fword = addr_q[`PPP_WORD_MSB:0];
  wire [`PPP_EE_BYTE_MSB:0] ebyte = addr_q[`PPP_EE_BYTE_MSB:0];
  wire [`PPP_EE_AW - 1:0] eaddr = addr_q[`PPP_EE_AW - 1:0];
  wire keep_eeprom_on_erase = !fuse_hi_q[`PPP_KEEP_EE_BIT];

  // Entry pattern caught at high-voltage rise, then held for the latch window
  // R10 entry latch
  always @(posedge CLK) begin
    if (RESET) begin
      PROG_MODE <= 1'b0;
      latch_arm_q <= 1'b0;
      latch_q <= 16'h0000;
    end else if (!hv) begin
      PROG_MODE <= 1'b0;
      latch_arm_q <= 1'b0;
    end else if (hv_rise) begin
      latch_arm_q <= (pen == 4'h0);
      latch_q <= 16'h0000;
    end else if (latch_arm_q) begin
      if (pen != 4'h0) begin
        latch_arm_q <= 1'b0;
      end else if (latch_q == LATCH_CYC[15:0]) begin
        PROG_MODE <= 1'b1;
        latch_arm_q <= 1'b0;
      end else begin
        latch_q <= latch_q + 16'h0001;
      end
    end
  end

  // Command, address and data byte loading
  always @(posedge CLK) begin
    if (RESET) begin
      cmd_q <= `PPP_CMD_NOP;
      addr_q <= 16'h0000;
      dat_q <= 16'h0000;
    end else if (PROG_MODE && ld_rise && idle) begin
      case (act)
        // R1 R7 address byte
        `PPP_ACT_ADDR: begin
          if (pick_a) begin
            addr_q[15:8] <= din;
          end else begin
            addr_q[7:0] <= din;
          end
        end
        // R2 R7 data byte
        `PPP_ACT_DATA: begin
          if (pick_a) begin
            dat_q[15:8] <= din;
          end else begin
            dat_q[7:0] <= din;
          end
        end
        // R3 R12 command kept
        `PPP_ACT_CMD: begin
          cmd_q <= din;
        end
        default: begin
        end
      endcase
    end
  end

  // Page latch into flash or EEPROM buffer
  // R18 R19 R21 page latch
  always @(posedge CLK) begin
    if (PROG_MODE && pgl_rise && idle) begin
      if (cmd_q == `PPP_CMD_WEE) begin
        ee_buf[ebyte] <= dat_q[7:0];
      end else begin
        page_buf[fword] <= dat_q;
      end
    end
  end

  // Operation sequencer with busy timing and memory writes
  integer i;
  always @(posedge CLK) begin
    if (RESET) begin
      st_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      walk_q <= 13'h0000;
      ee_op_q <= 1'b0;
      OP_DONE_FLAG <= 1'b1;
      fuse_lo_q <= `PPP_FUSE_LO_RST;
      fuse_hi_q <= `PPP_FUSE_HI_RST;
      fuse_ex_q <= `PPP_FUSE_EX_RST;
      lock_q <= `PPP_LOCK_RST;
    end else begin
      case (st_q)
        ST_IDLE: begin
          OP_DONE_FLAG <= 1'b1;
          cnt_q <= 16'h0000;
          // R6 R4 R26 write strobe starts command
          if (PROG_MODE && wr_fall && cmd_q != `PPP_CMD_NOP) begin
            // R9 R17 busy low
            OP_DONE_FLAG <= 1'b0;
            case (cmd_q)
              `PPP_CMD_ERASE: begin
                st_q <= ST_ERASE;
                walk_q <= 13'h0000;
              end
              `PPP_CMD_WFLASH: begin
                st_q <= ST_PROG;
                ee_op_q <= 1'b0;
              end
              `PPP_CMD_WEE: begin
                st_q <= ST_PROG;
                ee_op_q <= 1'b1;
              end
              // R8 fuse byte select
              `PPP_CMD_WFUSE: begin
                st_q <= ST_PROG;
                ee_op_q <= 1'b0;
                if (pick_b) begin
                  fuse_ex_q <= dat_q[7:0];
                end else if (pick_a) begin
                  fuse_hi_q <= dat_q[7:0];
                end else begin
                  fuse_lo_q <= dat_q[7:0];
                end
              end
              `PPP_CMD_WLOCK: begin
                st_q <= ST_PROG;
                ee_op_q <= 1'b0;
                lock_q <= lock_q & dat_q[7:0];
              end
              default: begin
                OP_DONE_FLAG <= 1'b1;
              end
            endcase
          end
        end
        // R20 R22 whole page committed at the end of the busy time
        ST_PROG: begin
          if (cnt_q == PROG_CYC[15:0] - 16'h0001) begin
            if (cmd_q == `PPP_CMD_WFLASH && !ee_op_q) begin
              for (i = 0; i < `PPP_PAGE_WORDS; i = i + 1) begin
                flash_mem[{fpage, i[`PPP_WORD_MSB:0]}] <= page_buf[i];
              end
            end else if (ee_op_q && cmd_q == `PPP_CMD_WEE) begin
              for (i = 0; i < `PPP_EE_PAGE_BYTES; i = i + 1) begin
                ee_mem[{eaddr[`PPP_EE_AW - 1:`PPP_EE_BYTE_MSB + 1],
                  i[`PPP_EE_BYTE_MSB:0]}] <= ee_buf[i];
              end
            end
            st_q <= ST_IDLE;
          end else if (cmd_q == `PPP_CMD_NOP) begin
            // R27 nop ends write
            st_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        // R15 R16 erase one flash word per cycle and, unless EEPROM is kept, one EEPROM byte in each of the first 512 cycles
        ST_ERASE: begin
          flash_mem[walk_q[`PPP_FLASH_AW - 1:0]] <= {`PPP_ERASED_BYTE, `PPP_ERASED_BYTE};
          if (!keep_eeprom_on_erase && walk_q < 13'h0200) begin
            ee_mem[walk_q[`PPP_EE_AW - 1:0]] <= `PPP_ERASED_BYTE;
          end
          if (walk_q[`PPP_FLASH_AW - 1:0] == {`PPP_FLASH_AW{1'b1}}) begin
            st_q <= ST_LOCK;
          end
          walk_q <= walk_q + 13'h0001;
        end
        // R15 locks after memory
        ST_LOCK: begin
          if (cnt_q == ERASE_CYC[15:0]) begin
            lock_q <= `PPP_LOCK_RST;
            st_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Read mux selected by the loaded command
  // R5 R7 R8 R25 read decode
  always @* begin
    rd_byte = 8'h00;
    case (cmd_q)
      `PPP_CMD_RSIG: begin
        if (pick_a) begin
          rd_byte = (addr_q[1:0] == 2'h0) ? CAL_BYTE : 8'h00;
        end else begin
          case (addr_q[1:0])
            2'h0: rd_byte = SIG0;
            2'h1: rd_byte = SIG1;
            2'h2: rd_byte = SIG2;
            default: rd_byte = 8'h00;
          endcase
        end
      end
      `PPP_CMD_RFUSE: begin
        case ({pick_b, pick_a})
          2'h0: rd_byte = fuse_lo_q;
          2'h1: rd_byte = lock_q;
          2'h2: rd_byte = fuse_ex_q;
          default: rd_byte = fuse_hi_q;
        endcase
      end
      `PPP_CMD_RFLASH: begin
        rd_byte = pick_a ? flash_mem[addr_q[`PPP_FLASH_AW - 1:0]][15:8]
          : flash_mem[addr_q[`PPP_FLASH_AW - 1:0]][7:0];
      end
      `PPP_CMD_REE: begin
        rd_byte = ee_mem[eaddr];
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Data bus drive while output enable is low
  // R6 output enable read
  always @(posedge CLK) begin
    if (RESET) begin
      DATA_OUT <= 8'h00;
      DATA_OE <= 1'b0;
      rd_push_q <= 1'b0;
    end else begin
      DATA_OE <= PROG_MODE && oe_low && idle;
      DATA_OUT <= rd_byte;
      rd_push_q <= PROG_MODE && idle && !oe_n && prev_q[0] && skid_ready;
    end
  end

  // Each read made while the buffer has room also goes to the user side through it
  wire [7:0] skid_data;
  wire skid_valid;
  ppp_skid ppp_skid_inst (
    .clk(CLK),
    .rst(RESET),
    .in_data(DATA_OUT),
    .in_valid(rd_push_q),
    .in_ready(skid_ready),
    .out_data(skid_data),
    .out_valid(skid_valid),
    .out_ready(!RD_VALID || RD_READY)
  );
  always @(posedge CLK) begin
    if (RESET) begin
      RD_VALID <= 1'b0;
      RD_DATA <= 8'h00;
    end else if (!RD_VALID || RD_READY) begin
      RD_VALID <= skid_valid;
      RD_DATA <= skid_data;
    end
  end

  // Oscillator trim loaded from the calibration byte during reset
  // R24 trim load
  always @(posedge CLK) begin
    if (RESET) begin
      OSC_TRIM_REGISTER <= CAL_BYTE;
    end
  end
endmodule // ppp_port
`default_nettype wire

// ### include/ppp_consts.vh
// Constants of the parallel programming port
`ifndef PPP_CONSTS_VH
`define PPP_CONSTS_VH
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_ACT_IDLE 2'h3
`define PPP_CMD_NOP 8'h00
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WFUSE 8'h40
`define PPP_CMD_WLOCK 8'h20
`define PPP_CMD_WFLASH 8'h10
`define PPP_CMD_WEE 8'h11
`define PPP_CMD_RSIG 8'h08
`define PPP_CMD_RFUSE 8'h04
`define PPP_CMD_RFLASH 8'h02
`define PPP_CMD_REE 8'h03
`define PPP_FLASH_AW 12
`define PPP_EE_AW 9
`define PPP_PAGE_WORDS 32
`define PPP_EE_PAGE_BYTES 4
`define PPP_WORD_MSB 4
`define PPP_EE_BYTE_MSB 1
`define PPP_ERASED_BYTE 8'hFF
`define PPP_FUSE_LO_RST 8'h62
`define PPP_FUSE_HI_RST 8'hDF
`define PPP_FUSE_EX_RST 8'hF9
`define PPP_LOCK_RST 8'hFF
`define PPP_KEEP_EE_BIT 3
`define PPP_PROG_US 10
`define PPP_ERASE_US 100
`define PPP_CLK_MHZ 20
`define PPP_LATCH_US 10
`endif

// ### hdl/ppp_skid.v
// Two-entry valid/ready buffer for read data
`timescale 1ns/100ps
`default_nettype none
module ppp_skid (
  input wire clk,
  input wire rst,
  input wire [7:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [7:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [7:0] mem_q [0:1];
  reg wr_q;
  reg rd_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Pointers and fill count
  always @(posedge clk) begin
    if (rst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
  // Storage
  always @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule // ppp_skid
`default_nettype wire

// ### verif/ppp_port_properties.sv
// Checker for the parallel programming port outputs
`timescale 1ns/100ps
`default_nettype none
module ppp_port_props #(
  parameter [7:0] CAL_BYTE = 8'h80
) (
  input wire CLK,
  input wire RESET,
  input wire HV_RESET,
  input wire [3:0] PROG_ENABLE,
  input wire WR_N,
  input wire OE_N,
  input wire DATA_OE,
  input wire OP_DONE_FLAG,
  input wire PROG_MODE,
  input wire [7:0] OSC_TRIM_REGISTER,
  input wire [7:0] RD_DATA,
  input wire RD_VALID,
  input wire RD_READY
);
  logic [12:0] busy_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // Counts the cycles of one busy stretch
  always @(posedge CLK) begin
    if (RESET || OP_DONE_FLAG) busy_q <= 13'h0000;
    else busy_q <= busy_q + 13'h0001;
  end
  a_reset_idle: assert property ($fell(RESET) |-> OP_DONE_FLAG && !PROG_MODE && !DATA_OE)
    else $error("outputs not idle after reset");
  a_trim_load: assert property ($fell(RESET) |-> OSC_TRIM_REGISTER == CAL_BYTE)
    else $error("trim value not loaded at reset");
  a_busy_cause: assert property ($fell(OP_DONE_FLAG) |-> PROG_MODE && (!$past(WR_N, 3) || !$past(WR_N, 4)))
    else $error("busy without write strobe");
  a_busy_max: assert property (busy_q < 13'h1838)
    else $error("busy too long");
  a_busy_min: assert property ($rose(OP_DONE_FLAG) |-> $past(busy_q) >= 13'h00BE)
    else $error("busy too short");
  a_oe_drive: assert property (DATA_OE |-> PROG_MODE && (!$past(OE_N, 2) || !$past(OE_N, 3)))
    else $error("bus driven without output enable");
  a_rd_hold: assert property (RD_VALID && !RD_READY |=> RD_VALID && $stable(RD_DATA))
    else $error("read byte dropped under stall");
  a_mode_entry: assert property ($rose(PROG_MODE) |-> $past(HV_RESET, 200) && $past(PROG_ENABLE, 200) == 4'h0)
    else $error("mode entered without pattern");
  a_idle_ready: assert property (!PROG_MODE |-> OP_DONE_FLAG)
    else $error("busy outside programming mode");
  c_entry: cover property ($rose(PROG_MODE));
  c_erase: cover property (busy_q == 13'h1000);
  c_stall: cover property (RD_VALID && !RD_READY);
endmodule // ppp_port_props
bind ppp_port ppp_port_props #(.CAL_BYTE(CAL_BYTE)) ppp_port_props_inst (
  .CLK(CLK), .RESET(RESET), .HV_RESET(HV_RESET), .PROG_ENABLE(PROG_ENABLE), .WR_N(WR_N),
  .OE_N(OE_N), .DATA_OE(DATA_OE), .OP_DONE_FLAG(OP_DONE_FLAG), .PROG_MODE(PROG_MODE),
  .OSC_TRIM_REGISTER(OSC_TRIM_REGISTER), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
  .RD_READY(RD_READY)
);
`default_nettype wire

// ### verif/ppp_programmer.sv
// Behavioural parallel programmer driving the port pins
`timescale 1ns/100ps
`default_nettype none
module ppp_programmer (
  input wire logic clk,
  input wire logic op_done_flag,
  output logic hv_reset,
  output logic [3:0] prog_enable,
  output logic load_strobe,
  output logic act0,
  output logic act1,
  output logic pick_a,
  output logic pick_b,
  output logic page_latch_strobe,
  output logic wr_n,
  output logic oe_n,
  output logic [7:0] data_in
);
  logic [1:0] rdy_sync;
  // Entry pattern shares the strobe and select pins
  assign prog_enable = {page_latch_strobe, act1, act0, pick_a};
  always @(posedge clk) rdy_sync <= {rdy_sync[0], op_done_flag};
  // Idle pins; load strobe stands still outside frames
  initial begin
    {hv_reset, load_strobe, act0, act1, pick_a, pick_b, page_latch_strobe} = 7'h00;
    {wr_n, oe_n} = 2'h3;
    data_in = 8'hA5;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic enter();
    hv_reset <= 1'b1;
    tick(6000);
  endtask
  task automatic load(input logic [1:0] act, input logic pa, input logic [7:0] d);
    {act1, act0} <= act;
    pick_a <= pa;
    data_in <= d;
    tick(2);
    load_strobe <= 1'b1;
    tick(4);
    load_strobe <= 1'b0;
    tick(2);
    // Bus shows the inverse once the frame is over
    data_in <= ~d;
    tick(2);
  endtask
  task automatic latch();
    page_latch_strobe <= 1'b1;
    tick(4);
    page_latch_strobe <= 1'b0;
    tick(4);
  endtask
  task automatic wr(output logic busy, output int waited);
    wr_n <= 1'b0;
    tick(5);
    busy = op_done_flag;
    wr_n <= 1'b1;
    tick(3);
    waited = 0;
    while (rdy_sync[1] !== 1'b1 && waited < 7000) begin
      tick(1);
      waited++;
    end
  endtask
  task automatic rd(input logic pa, input logic pb);
    pick_a <= pa;
    pick_b <= pb;
    tick(1);
    oe_n <= 1'b0;
    tick(4);
    oe_n <= 1'b1;
    tick(4);
  endtask
endmodule // ppp_programmer
`default_nettype wire

// ### verif/ppp_port_tb.sv
// Self-checking bench for the parallel programming port
`timescale 1ns/100ps
`default_nettype none
`include "ppp_consts.vh"
module ppp_port_tb;
  localparam logic [7:0] CAL = 8'h3C;
  localparam logic [7:0] SIG [3] = '{8'hC1, 8'hD2, 8'hE3}; // Arbitrary identity values
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic rd_ready = 1'b0;
  logic hold = 1'b0;
  wire hv, ls, a0, a1, pa, pb, pl, wr_n, oe_n, data_oe, done, mode, rd_valid;
  wire [3:0] pen;
  wire [7:0] din, dout, trim, rd_data;
  logic [7:0] q [$];
  logic [15:0] pg [32];
  logic [15:0] addr;
  logic [6:0] page;
  logic bz;
  logic [7:0] bus_exp;
  localparam logic [7:0] KEEP_FUSE = `PPP_FUSE_HI_RST & ~(8'h01 << `PPP_KEEP_EE_BIT);
  localparam logic [7:0] LOCK_SET = 8'hFC;
  int w;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  ppp_port #(.SIG0(SIG[0]), .SIG1(SIG[1]), .SIG2(SIG[2]), .CAL_BYTE(CAL)) ppp_port_inst (
    .CLK(clk), .RESET(reset), .HV_RESET(hv), .PROG_ENABLE(pen), .LOAD_STROBE(ls),
    .ACTION_CODE_BIT0(a0), .ACTION_CODE_BIT1(a1), .BYTE_PICK_A(pa), .BYTE_PICK_B(pb),
    .PAGE_LATCH_STROBE(pl), .WR_N(wr_n), .OE_N(oe_n), .DATA_IN(din), .DATA_OUT(dout),
    .DATA_OE(data_oe), .OP_DONE_FLAG(done), .PROG_MODE(mode), .OSC_TRIM_REGISTER(trim),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_READY(rd_ready));
  ppp_programmer ppp_programmer_inst (
    .clk(clk), .op_done_flag(done), .hv_reset(hv), .prog_enable(pen), .load_strobe(ls),
    .act0(a0), .act1(a1), .pick_a(pa), .pick_b(pb), .page_latch_strobe(pl), .wr_n(wr_n),
    .oe_n(oe_n), .data_in(din));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic ld(input logic [1:0] act, input logic p, input logic [7:0] d);
    ppp_programmer_inst.load(act, p, d);
  endtask
  task automatic rx(input logic p, input logic b, input logic [7:0] exp);
    q.push_back(exp);
    bus_exp = exp;
    ppp_programmer_inst.rd(p, b);
  endtask
  task automatic wrx();
    ppp_programmer_inst.wr(bz, w);
    check({7'h00, bz}, 8'h00);
    check({7'h00, w >= 7000}, 8'h00);
  endtask
  // Random receiver stall and run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_ready <= !hold && ($urandom % 4 != 0);
    if (cyc == 60000) begin
      n_errors++;
      stop_test();
    end
  end
  // Scoreboard on accepted read bytes
  always @(negedge clk) begin
    if (rd_valid === 1'b1 && rd_ready) begin
      if (q.size() == 0) begin
        n_errors++;
        $display("BAD %0t unexpected read byte", $time);
      end else check(rd_data, q.pop_front());
    end
    if (data_oe === 1'b1) check(dout, bus_exp);
  end
  initial begin
    void'($urandom(70));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    @(negedge clk);
    check({4'h0, done, mode, data_oe, rd_valid}, 8'h08);
    check(trim, CAL);
    @(posedge clk);
    ppp_programmer_inst.enter();
    check({7'h00, mode}, 8'h01);
    // idle action ignored; signatures under stall
    ld(2'h2, 1'b0, `PPP_CMD_RSIG);
    ld(2'h3, 1'b0, `PPP_CMD_RFLASH);
    for (int i = 0; i < 3; i++) begin
      ld(2'h0, 1'b0, 8'(i));
      hold <= (i < 2);
      rx(1'b0, 1'b0, SIG[i]);
    end
    ld(2'h0, 1'b0, 8'h00);
    rx(1'b1, 1'b0, CAL);
    // fuse and lock bytes by pick lines
    ld(2'h2, 1'b0, `PPP_CMD_RFUSE);
    rx(1'b0, 1'b0, `PPP_FUSE_LO_RST);
    rx(1'b1, 1'b1, `PPP_FUSE_HI_RST);
    rx(1'b0, 1'b1, `PPP_FUSE_EX_RST);
    rx(1'b1, 1'b0, `PPP_LOCK_RST);
    ld(2'h2, 1'b0, `PPP_CMD_ERASE);
    wrx();
    ld(2'h2, 1'b0, `PPP_CMD_RFUSE);
    rx(1'b1, 1'b1, `PPP_FUSE_HI_RST);
    page = 7'($urandom);
    for (int m = 0; m < 2; m++) begin
      addr = m ? {7'h00, page, 2'h0} : {4'h0, page, 5'h00};
      ld(2'h2, 1'b0, m ? `PPP_CMD_REE : `PPP_CMD_RFLASH);
      ld(2'h0, 1'b1, addr[15:8]);
      ld(2'h0, 1'b0, addr[7:0]);
      rx(1'b0, 1'b0, `PPP_ERASED_BYTE);
      ld(2'h2, 1'b0, m ? `PPP_CMD_WEE : `PPP_CMD_WFLASH);
      ld(2'h0, 1'b1, addr[15:8]);
      for (int i = 0; i < (m ? 4 : 32); i++) begin
        pg[i] = 16'($urandom);
        ld(2'h0, 1'b0, addr[7:0] + 8'(i));
        ld(2'h1, 1'b0, pg[i][7:0]);
        if (m == 0) ld(2'h1, 1'b1, pg[i][15:8]);
        ppp_programmer_inst.latch();
      end
      ld(2'h1, 1'b0, pg[0][7:0]);
      wrx();
      ld(2'h2, 1'b0, `PPP_CMD_NOP);
      // read back with one command load
      ld(2'h2, 1'b0, m ? `PPP_CMD_REE : `PPP_CMD_RFLASH);
      ld(2'h0, 1'b1, addr[15:8]);
      for (int i = 0; i < (m ? 4 : 32); i++) begin
        ld(2'h0, 1'b0, addr[7:0] + 8'(i));
        rx(1'b0, 1'b0, pg[i][7:0]);
        if (m == 0) rx(1'b1, 1'b0, pg[i][15:8]);
      end
    end
    // program keep-EEPROM fuse, then lock bits
    ld(2'h2, 1'b0, `PPP_CMD_WFUSE);
    ld(2'h1, 1'b0, KEEP_FUSE);
    ld(2'h3, 1'b1, 8'h00);
    wrx();
    ld(2'h2, 1'b0, `PPP_CMD_WLOCK);
    ld(2'h1, 1'b0, LOCK_SET);
    wrx();
    ld(2'h2, 1'b0, `PPP_CMD_RFUSE);
    rx(1'b1, 1'b1, KEEP_FUSE);
    rx(1'b1, 1'b0, `PPP_LOCK_RST & LOCK_SET);
    ld(2'h2, 1'b0, `PPP_CMD_ERASE);
    wrx();
    ld(2'h2, 1'b0, `PPP_CMD_RFUSE);
    rx(1'b1, 1'b0, `PPP_LOCK_RST);
    ld(2'h2, 1'b0, `PPP_CMD_REE);
    ld(2'h0, 1'b0, addr[7:0]);
    rx(1'b0, 1'b0, pg[0][7:0]);
    repeat (40) @(posedge clk);
    check(8'(q.size()), 8'h00);
    stop_test();
  end
endmodule // ppp_port_tb
`default_nettype wire
